// ==== dv/cio_pad_model.sv ====
// Purpose: Pad side: outside drivers, pull resistors and floating pins
// Assumes: Twenty pins flattened, first port in the low bits
// Notes: A floating pin toggles every clock so a stale level never reads as valid
module cio_pad_model
(
   input wire logic clk_i,
   input wire logic [19:0] drive_i,
   input wire logic [19:0] oe_n_i,
   input wire logic [19:0] pull_up_i,
   input wire logic [3:0] pull_down_i,
   input wire logic [19:0] ext_en_i,
   input wire logic [19:0] ext_val_i,
   output logic [19:0] level_o
);
   timeunit 1ns / 1ps;
   logic flip = 1'b0;
   // Floating pattern
   always_ff @(posedge clk_i) flip <= !flip;
   // Wire level; device drive wins
   always_comb
   begin
      for (int i = 0; i < 20; i++)
      begin
         if (!oe_n_i[i]) level_o[i] = drive_i[i];
         else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
         else if (pull_up_i[i]) level_o[i] = 1'b1;
         else if (i < 4 && pull_down_i[i[1:0]]) level_o[i] = 1'b0;
         else level_o[i] = flip ^ i[0];
      end
   end
endmodule // cio_pad_model

// ==== dv/cio_ports_props.sv ====
// Purpose: Port-level checks for the configurable I/O ports
// Assumes: Sees top ports only; register contents are inferred
// Notes: Bound to every cio_ports instance
module cio_ports_props
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [3:0] p0_pad_i,
   input wire logic [3:0] p0_pad_o,
   input wire logic [3:0] p0_pad_oe_n_o,
   input wire logic [3:0] p0_pull_up_o,
   input wire logic [3:0] p0_pull_down_o,
   input wire logic [7:0] p1_pad_o,
   input wire logic [7:0] p1_pad_oe_n_o,
   input wire logic [7:0] p1_pull_up_o,
   input wire logic [7:0] p2_pad_o,
   input wire logic [7:0] p2_pad_oe_n_o,
   input wire logic [7:0] p2_pull_up_o,
   input wire logic p0_edge_event_o
);
   timeunit 1ns / 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic wr_seen;
   logic [2:0] age;
   // First write seen; age keeps $past out of reset
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_seen <= 1'b0;
         age <= 3'h0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o) wr_seen <= 1'b1;
         if (age != 3'h7) age <= age + 3'h1;
      end
   end
   sequence s_wr_taken;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence s_wr_answer;
      s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o;
   endsequence
   a_write_answer: assert property (s_wr_taken |=> !s_axi_awready_o ##1 s_wr_answer)
      else $error("write answer late");
   a_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped");
   a_pull_low_off: assert property (!(|(~p1_pad_oe_n_o & ~p1_pad_o & p1_pull_up_o)) &&
      !(|(~p2_pad_oe_n_o & ~p2_pad_o & p2_pull_up_o)) && !(|(~p0_pad_oe_n_o & ~p0_pad_o & (p0_pull_up_o | p0_pull_down_o))))
      else $error("pull on while driving low");
   a_pull_exclusive: assert property (!(|(p0_pull_up_o & p0_pull_down_o)))
      else $error("pull-up and pull-down together");
   a_reset_input: assert property (!wr_seen |-> &{p0_pad_oe_n_o, p1_pad_oe_n_o, p2_pad_oe_n_o})
      else $error("pin driven before any write");
   a_event_cause: assert property (p0_edge_event_o && age == 3'h7 |-> $past(p0_pad_i, 3) != $past(p0_pad_i, 4))
      else $error("edge event without pad change");
   c_event: cover property (p0_edge_event_o);
endmodule // cio_ports_props

bind cio_ports cio_ports_props chk_u (.clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
   .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
   .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .p0_pad_i, .p0_pad_o, .p0_pad_oe_n_o, .p0_pull_up_o,
   .p0_pull_down_o, .p1_pad_o, .p1_pad_oe_n_o, .p1_pull_up_o, .p2_pad_o, .p2_pad_oe_n_o, .p2_pull_up_o,
   .p0_edge_event_o);

// ==== dv/test_configurable_io_ports.sv ====
// Purpose: Self-checking bench for the configurable I/O ports
// Assumes: AXI4-Lite master in the bench, pad model on the far side
// Notes: Pad expectations come from a shadow of every written register
module test_configurable_io_ports;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [9:0] awaddr = 10'h000;
   logic [9:0] araddr = 10'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, pulse = 1'b0, alt = 1'b0;
   wire logic awready, wready, bvalid, arready, rvalid, ev;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [19:0] o_all, oe_all, pu_all, lvl;
   wire logic [3:0] pd;
   logic [19:0] ext_en = 20'h0, ext_val = 20'h0;
   logic [7:0] sh[3][4] = '{default: 8'h00};
   logic [7:0] base[3] = '{cio_pkg::IDX_P0_DATA, cio_pkg::IDX_P1_DATA, cio_pkg::IDX_P2_DATA};
   logic [31:0] seed = 32'h0000a541;
   logic [33:0] qr[$];
   logic [1:0] qb[$];
   int n_fail = 0, n_compared = 0, nev = 0, n0 = 0;

   cio_ports dut_u (.clk_i(clk), .arst_n_i(arst_n), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .pulse_out_i(pulse), .p0_pad_i(lvl[3:0]), .p0_pad_o(o_all[3:0]),
      .p0_pad_oe_n_o(oe_all[3:0]), .p0_pull_up_o(pu_all[3:0]), .p0_pull_down_o(pd), .p1_pad_i(lvl[11:4]),
      .p1_pad_o(o_all[11:4]), .p1_pad_oe_n_o(oe_all[11:4]), .p1_pull_up_o(pu_all[11:4]), .p2_pad_i(lvl[19:12]),
      .p2_pad_o(o_all[19:12]), .p2_pad_oe_n_o(oe_all[19:12]), .p2_pull_up_o(pu_all[19:12]), .p0_edge_event_o(ev));
   cio_pad_model pad_u (.clk_i(clk), .drive_i(o_all), .oe_n_i(oe_all), .pull_up_i(pu_all), .pull_down_i(pd),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));

   // Clock
   always #5 clk = !clk;
   // Event counter
   always @(posedge clk) if (ev) nev <= nev + 1;
   // Bus answers against the oldest note; negedge sees the handshake settled
   always @(negedge clk)
   begin
      if (rvalid && rready) chk({30'h0, rresp, rdata}, {30'h0, qr.pop_front()});
      if (bvalid && bready) chk({62'h0, bresp}, {62'h0, qb.pop_front()});
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected pad outputs: {oe_n, driven level, pull-up, pull-down}
   function automatic logic [63:0] pads_exp();
      int p;
      int b;
      logic out, lv, drv, on;
      logic [19:0] oe, o, pu;
      logic [3:0] pdn;
      pdn = 4'h0;
      for (int i = 0; i < 20; i++)
      begin
         p = (i < 4) ? 0 : (i < 12) ? 1 : 2;
         b = (i < 4) ? i : (i < 12) ? i - 4 : i - 12;
         out = sh[p][1][b];
         lv = (i == 3 && alt) ? pulse : sh[p][0][b];
         drv = out && !(sh[p][3][b] && lv);
         on = sh[p][2][b] && !(drv && !lv);
         oe[i] = !drv;
         o[i] = drv && lv;
         pu[i] = on && !(p == 0 && sh[0][2][4]);
         if (i < 4) pdn[i] = on && sh[0][2][4];
      end
      return {oe, o, pu, pdn};
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_pads();
      chk({oe_all, o_all & ~oe_all, pu_all, pd}, pads_exp());
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = cio_pkg::RESP_OKAY);
      logic a, w, b;
      qb.push_back(er);
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge clk);
         a = awvalid && awready;
         w = wvalid && wready;
         b = bvalid && bready;
         @(posedge clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      while (!b);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = cio_pkg::RESP_OKAY);
      logic a, r;
      qr.push_back({er, d});
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge clk);
         a = arvalid && arready;
         r = rvalid && rready;
         @(posedge clk);
         if (a) arvalid <= 1'b0;
      end
      while (!r);
      rready <= 1'b0;
   endtask

   // Random settings for all twelve port registers, then pads and read-back
   task automatic cfg_check();
      logic [31:0] r;
      logic [7:0] e;
      for (int p = 0; p < 3; p++)
         for (int k = 0; k < 4; k++)
         begin
            r = rnd();
            wr(base[p] + 8'(k), r[7:0]);
            sh[p][k] = r[7:0];
         end
      r = rnd();
      ext_en <= ~{sh[2][1], sh[1][1], sh[0][1][3:0]};
      ext_val <= r[19:0];
      repeat (3) @(posedge clk);
      chk_pads();
      for (int p = 0; p < 3; p++)
      begin
         e = (p == 0) ? {4'h0, ext_val[3:0]} : (p == 1) ? ext_val[11:4] : ext_val[19:12];
         rd(base[p], {24'h0, e & ~sh[p][1]});
         rd(base[p] + 8'h1, 32'h0);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk_pads();
      $display("test reset_state done");
      for (int t = 0; t < 8; t++) cfg_check();
      $display("test random_config done");
      wr(cio_pkg::IDX_P0_DIR, 8'h00);
      sh[0][1] = 8'h00;
      ext_en[3:0] <= 4'hf;
      ext_val[3:0] <= 4'h1;
      for (int k = 0; k < 4; k++)
      begin
         wr(cio_pkg::IDX_P0_PULL, {3'h0, k[1], 4'hf});
         sh[0][2] = {3'h0, k[1], 4'hf};
         repeat (6) @(posedge clk);
         n0 = nev;
         ext_val[0] <= k[0];
         repeat (8) @(posedge clk);
         chk(64'(nev - n0), 64'(k[0] == k[1]));
      end
      $display("test edge_event done");
      wr(cio_pkg::IDX_P0_DIR, 8'h08);
      sh[0][1] = 8'h08;
      wr(cio_pkg::IDX_IO_FUNC, 8'h01);
      alt = 1'b1;
      for (int v = 0; v < 2; v++)
      begin
         pulse <= v[0];
         repeat (3) @(posedge clk);
         chk_pads();
      end
      rd(cio_pkg::IDX_IO_FUNC, 32'h1);
      $display("test alternate_output done");
      wr(8'hd1, 8'h5a, cio_pkg::RESP_SLVERR);
      rd(8'hd6, 32'h0, cio_pkg::RESP_SLVERR);
      chk_pads();
      $display("test unmapped done");
      stop_test();
   end

   // Watchdog, far beyond the roughly seven hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test();
   end
endmodule // test_configurable_io_ports

// ==== src/cio_pin_cell.sv ====
// Purpose: One pad cell: input synchroniser plus registered drive, enable and pulls
// Assumes: Control settings arrive on clk_i; pad input is asynchronous
// Notes: Outputs lag control changes by one clock
module cio_pin_cell
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire cio_pkg::cio_pin_ctrl_type ctrl_i,
   input wire logic pad_i,
   output cio_pkg::cio_pin_pad_type pad_o,
   output logic sync_o
);

   logic meta;
   cio_pkg::cio_pin_pad_type next_pad;

   // Two-stage synchroniser, first stage feeds only the second
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         meta <= pad_i;
         sync_o <= meta;
      end
   end

   // Drive and pull decisions
   always_comb
   begin
      next_pad.drive = ctrl_i.out_en & ctrl_i.level;
      // Open drain only drives the low level, push-pull drives both
      next_pad.oe_n = ~(ctrl_i.out_en & (~ctrl_i.open_drain | ~ctrl_i.level));
      // Pull released while the pin outputs low
      next_pad.pull_up = ctrl_i.pull_en & ~ctrl_i.pull_down & ~(ctrl_i.out_en & ~ctrl_i.level);
      next_pad.pull_down = ctrl_i.pull_en & ctrl_i.pull_down & ~(ctrl_i.out_en & ~ctrl_i.level);
   end

   // Registered pad outputs, inputs and no pulls after reset
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pad_o <= '{drive: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0};
      else
         pad_o <= next_pad;
   end

endmodule // cio_pin_cell

// ==== src/cio_pkg.sv ====
// Purpose: Shared constants and carrier types for the configurable I/O ports
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: Register indices are kept as printed; byte address is four times the index
// Behaviour
// - First port has four direction-selectable pins
// - Second and third ports have eight pins each
// - Input pin reads back sampled pad level
// - Output pin drives latch, reads back zero
// - Direction bit 0 input, 1 output; resets 0
// - Port 1/2 direction bit n controls pin n
// - First port bit 4 picks pull-up or pull-down
// - First port bits 3..0 enable pull per pin
// - First port pull off while driving low
// - Port 1/2 pull-up enables, off when driving low
// - First port open-drain bits, default push-pull
// - First port input falling edge (bit 4 clear) or rising edge (bit 4 set) raises port event
// - Alternate select puts pulse output on pin 3
package cio_pkg;

   // Register indices, byte address is index times four
   localparam logic [7:0] IDX_IO_FUNC = 8'hd0;
   localparam logic [7:0] IDX_P0_DATA = 8'hd2;
   localparam logic [7:0] IDX_P0_DIR = 8'hd3;
   localparam logic [7:0] IDX_P0_PULL = 8'hd4;
   localparam logic [7:0] IDX_P0_OD = 8'hd5;
   localparam logic [7:0] IDX_P1_DATA = 8'hd7;
   localparam logic [7:0] IDX_P1_DIR = 8'hd8;
   localparam logic [7:0] IDX_P1_PULLUP = 8'hd9;
   localparam logic [7:0] IDX_P1_OD = 8'hda;
   localparam logic [7:0] IDX_P2_DATA = 8'hdc;
   localparam logic [7:0] IDX_P2_DIR = 8'hdd;
   localparam logic [7:0] IDX_P2_PULLUP = 8'hde;
   localparam logic [7:0] IDX_P2_OD = 8'hdf;

   // Field positions
   localparam int PULL_TYPE_BIT = 4;
   localparam int ALT_SELECT_BIT = 0;
   localparam int ALT_PIN = 3;

   // Pin counts and flat pin numbering
   localparam int P0_PINS = 4;
   localparam int P1_PINS = 8;
   localparam int P2_PINS = 8;
   localparam int P1_BASE = P0_PINS;
   localparam int P2_BASE = P0_PINS + P1_PINS;
   localparam int ALL_PINS = P0_PINS + P1_PINS + P2_PINS;

   // Values after reset
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [4:0] RST_P0_PULL = 5'h00;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Settings one pin needs from the register file
   typedef struct packed {
      logic out_en;
      logic level;
      logic open_drain;
      logic pull_en;
      logic pull_down;
   } cio_pin_ctrl_type;

   // What one pin presents to its pad
   typedef struct packed {
      logic drive;
      logic oe_n;
      logic pull_up;
      logic pull_down;
   } cio_pin_pad_type;

endpackage

// ==== src/cio_ports.sv ====
// Purpose: Three general-purpose I/O ports behind an AXI4-Lite slave
// Assumes: 100 MHz clk_i; pads asynchronous; pulse_out_i from logic on clk_i
// Notes: Write response two cycles after both halves taken; read data one cycle after address
//
// Design decision made here: register access over AXI4-Lite.
module cio_ports
#(
   parameter int ADDR_W = 10
)
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic [2:0] s_axi_awprot_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic [2:0] s_axi_arprot_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Pulse-width signal offered as pin 3 alternate output
   input wire logic pulse_out_i,
   // First port pads
   input wire logic [3:0] p0_pad_i,
   output logic [3:0] p0_pad_o,
   output logic [3:0] p0_pad_oe_n_o,
   output logic [3:0] p0_pull_up_o,
   output logic [3:0] p0_pull_down_o,
   // Second port pads
   input wire logic [7:0] p1_pad_i,
   output logic [7:0] p1_pad_o,
   output logic [7:0] p1_pad_oe_n_o,
   output logic [7:0] p1_pull_up_o,
   // Third port pads
   input wire logic [7:0] p2_pad_i,
   output logic [7:0] p2_pad_o,
   output logic [7:0] p2_pad_oe_n_o,
   output logic [7:0] p2_pull_up_o,
   // First port edge event toward the interrupt controller
   output logic p0_edge_event_o
);

   localparam int N = cio_pkg::ALL_PINS;

   // Register file
   logic [3:0] first_port_output_latch;
   logic [3:0] first_port_direction;
   logic [4:0] first_port_pull_control;
   logic [3:0] first_port_open_drain;
   logic [7:0] second_port_output_latch;
   logic [7:0] second_port_direction;
   logic [7:0] second_port_pullup_enable;
   logic [7:0] second_port_open_drain;
   logic [7:0] third_port_output_latch;
   logic [7:0] third_port_direction;
   logic [7:0] third_port_pullup_enable;
   logic [7:0] third_port_open_drain;
   logic pulse_output_alternate_select;

   // Bus state
   logic aw_got;
   logic w_got;
   logic [7:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane0;
   logic do_write;
   logic [7:0] ar_idx;

   // Pin-level wiring
   cio_pkg::cio_pin_ctrl_type pin_ctrl [N];
   cio_pkg::cio_pin_pad_type pin_pad [N];
   logic [N-1:0] pad_in;
   logic [N-1:0] pad_sync;
   logic [N-1:0] all_dir;
   logic [N-1:0] all_latch;
   logic [N-1:0] all_od;
   logic [N-1:0] all_pull_en;
   logic [3:0] p0_prev;
   logic [3:0] p0_edges;

   // Whether a word index names a register of this block
   function automatic logic reg_hit(input logic [7:0] idx);
      case (idx)
         cio_pkg::IDX_IO_FUNC, cio_pkg::IDX_P0_DATA, cio_pkg::IDX_P0_DIR,
         cio_pkg::IDX_P0_PULL, cio_pkg::IDX_P0_OD, cio_pkg::IDX_P1_DATA,
         cio_pkg::IDX_P1_DIR, cio_pkg::IDX_P1_PULLUP, cio_pkg::IDX_P1_OD,
         cio_pkg::IDX_P2_DATA, cio_pkg::IDX_P2_DIR, cio_pkg::IDX_P2_PULLUP,
         cio_pkg::IDX_P2_OD:
            reg_hit = 1'b1;
         default:
            reg_hit = 1'b0;
      endcase
   endfunction

   // Write address channel, one write in flight
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_awready_o <= 1'b0;
         aw_got <= 1'b0;
         aw_idx <= cio_pkg::RST_BYTE;
      end
      else if (s_axi_awready_o && s_axi_awvalid_i)
      begin
         s_axi_awready_o <= 1'b0;
         aw_got <= 1'b1;
         aw_idx <= s_axi_awaddr_i[9:2];
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
      begin
         aw_got <= 1'b0;
         s_axi_awready_o <= 1'b1;
      end
      else if (!aw_got && !s_axi_bvalid_o)
         s_axi_awready_o <= 1'b1;
   end

   // Write data channel, only the low byte lane carries data
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_wready_o <= 1'b0;
         w_got <= 1'b0;
         w_byte <= cio_pkg::RST_BYTE;
         w_lane0 <= 1'b0;
      end
      else if (s_axi_wready_o && s_axi_wvalid_i)
      begin
         s_axi_wready_o <= 1'b0;
         w_got <= 1'b1;
         w_byte <= s_axi_wdata_i[7:0];
         w_lane0 <= s_axi_wstrb_i[0];
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
      begin
         w_got <= 1'b0;
         s_axi_wready_o <= 1'b1;
      end
      else if (!w_got && !s_axi_bvalid_o)
         s_axi_wready_o <= 1'b1;
   end

   // A write lands once, when both halves are held; a missing lane 0 strobe stores nothing
   assign do_write = aw_got && w_got && !s_axi_bvalid_o && w_lane0;

   // Write response
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= cio_pkg::RESP_OKAY;
      end
      else if (aw_got && w_got && !s_axi_bvalid_o)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= reg_hit(aw_idx) ? cio_pkg::RESP_OKAY : cio_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // First port registers; upper bits have no storage
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         first_port_output_latch <= cio_pkg::RST_NIBBLE;
         first_port_direction <= cio_pkg::RST_NIBBLE;
         first_port_pull_control <= cio_pkg::RST_P0_PULL;
         first_port_open_drain <= cio_pkg::RST_NIBBLE;
         pulse_output_alternate_select <= 1'b0;
      end
      else if (do_write)
      begin
         case (aw_idx)
            cio_pkg::IDX_P0_DATA: first_port_output_latch <= w_byte[3:0];
            cio_pkg::IDX_P0_DIR: first_port_direction <= w_byte[3:0];
            cio_pkg::IDX_P0_PULL: first_port_pull_control <= w_byte[4:0];
            cio_pkg::IDX_P0_OD: first_port_open_drain <= w_byte[3:0];
            cio_pkg::IDX_IO_FUNC: pulse_output_alternate_select <= w_byte[cio_pkg::ALT_SELECT_BIT];
            default: ;
         endcase
      end
   end

   // Second and third port registers
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         second_port_output_latch <= cio_pkg::RST_BYTE;
         second_port_direction <= cio_pkg::RST_BYTE;
         second_port_pullup_enable <= cio_pkg::RST_BYTE;
         second_port_open_drain <= cio_pkg::RST_BYTE;
         third_port_output_latch <= cio_pkg::RST_BYTE;
         third_port_direction <= cio_pkg::RST_BYTE;
         third_port_pullup_enable <= cio_pkg::RST_BYTE;
         third_port_open_drain <= cio_pkg::RST_BYTE;
      end
      else if (do_write)
      begin
         case (aw_idx)
            cio_pkg::IDX_P1_DATA: second_port_output_latch <= w_byte;
            cio_pkg::IDX_P1_DIR: second_port_direction <= w_byte;
            cio_pkg::IDX_P1_PULLUP: second_port_pullup_enable <= w_byte;
            cio_pkg::IDX_P1_OD: second_port_open_drain <= w_byte;
            cio_pkg::IDX_P2_DATA: third_port_output_latch <= w_byte;
            cio_pkg::IDX_P2_DIR: third_port_direction <= w_byte;
            cio_pkg::IDX_P2_PULLUP: third_port_pullup_enable <= w_byte;
            cio_pkg::IDX_P2_OD: third_port_open_drain <= w_byte;
            default: ;
         endcase
      end
   end

   // Read channel; output pins read as zero, direction and pull registers read zero
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= cio_pkg::RESP_OKAY;
      end
      else if (s_axi_arready_o && s_axi_arvalid_i)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o <= reg_hit(ar_idx) ? cio_pkg::RESP_OKAY : cio_pkg::RESP_SLVERR;
         case (ar_idx)
            cio_pkg::IDX_P0_DATA:
               s_axi_rdata_o <= {28'h000_0000, pad_sync[3:0] & ~first_port_direction};
            cio_pkg::IDX_P1_DATA:
               s_axi_rdata_o <= {24'h00_0000, pad_sync[11:4] & ~second_port_direction};
            cio_pkg::IDX_P2_DATA:
               s_axi_rdata_o <= {24'h00_0000, pad_sync[19:12] & ~third_port_direction};
            cio_pkg::IDX_IO_FUNC:
               s_axi_rdata_o <= {31'h0000_0000, pulse_output_alternate_select};
            default:
               s_axi_rdata_o <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
      else if (!s_axi_rvalid_o)
         s_axi_arready_o <= 1'b1;
   end

   assign ar_idx = s_axi_araddr_i[9:2];

   // Flatten per-port settings into one pin numbering
   assign all_dir = {third_port_direction, second_port_direction, first_port_direction};
   assign all_latch = {third_port_output_latch, second_port_output_latch, first_port_output_latch};
   assign all_od = {third_port_open_drain, second_port_open_drain, first_port_open_drain};
   assign all_pull_en = {third_port_pullup_enable, second_port_pullup_enable, first_port_pull_control[3:0]};
   assign pad_in = {p2_pad_i, p1_pad_i, p0_pad_i};

   // One pad cell per pin
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_pin
         always_comb
         begin
            pin_ctrl[g].out_en = all_dir[g];
            // Alternate output replaces the latch on pin 3 whenever the alternate select bit is set
            if (g == cio_pkg::ALT_PIN && pulse_output_alternate_select)
               pin_ctrl[g].level = pulse_out_i;
            else
               pin_ctrl[g].level = all_latch[g];
            pin_ctrl[g].open_drain = all_od[g];
            pin_ctrl[g].pull_en = all_pull_en[g];
            // Pull-down exists only on the first port
            pin_ctrl[g].pull_down = (g < cio_pkg::P0_PINS) ?
               first_port_pull_control[cio_pkg::PULL_TYPE_BIT] : 1'b0;
         end

         cio_pin_cell u_cell
         (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .ctrl_i(pin_ctrl[g]),
            .pad_i(pad_in[g]),
            .pad_o(pin_pad[g]),
            .sync_o(pad_sync[g])
         );

         // Route cell outputs to the port pins
         if (g < cio_pkg::P1_BASE)
         begin : g_p0
            assign p0_pad_o[g] = pin_pad[g].drive;
            assign p0_pad_oe_n_o[g] = pin_pad[g].oe_n;
            assign p0_pull_up_o[g] = pin_pad[g].pull_up;
            assign p0_pull_down_o[g] = pin_pad[g].pull_down;
         end
         else if (g < cio_pkg::P2_BASE)
         begin : g_p1
            assign p1_pad_o[g-cio_pkg::P1_BASE] = pin_pad[g].drive;
            assign p1_pad_oe_n_o[g-cio_pkg::P1_BASE] = pin_pad[g].oe_n;
            assign p1_pull_up_o[g-cio_pkg::P1_BASE] = pin_pad[g].pull_up;
         end
         else
         begin : g_p2
            assign p2_pad_o[g-cio_pkg::P2_BASE] = pin_pad[g].drive;
            assign p2_pad_oe_n_o[g-cio_pkg::P2_BASE] = pin_pad[g].oe_n;
            assign p2_pull_up_o[g-cio_pkg::P2_BASE] = pin_pad[g].pull_up;
         end
      end
   endgenerate

   // Edge direction follows the pull type: falling with pull-up, rising with pull-down
   assign p0_edges = first_port_pull_control[cio_pkg::PULL_TYPE_BIT] ?
      (pad_sync[3:0] & ~p0_prev) : (~pad_sync[3:0] & p0_prev);

   // Port event pulse, input pins only
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         p0_prev <= cio_pkg::RST_NIBBLE;
         p0_edge_event_o <= 1'b0;
      end
      else
      begin
         p0_prev <= pad_sync[3:0];
         p0_edge_event_o <= |(p0_edges & ~first_port_direction);
      end
   end

endmodule // cio_ports
